// *** logic/asr_readout.sv ***
/*
 * Serial read-out of converter results: null bit, result MSB first,
 * then LSB first, then zeros, shifted on falling serial clock edges.
 * Assumes serial clock and select pins are asynchronous to CLK and the
 * serial clock is well below CLK/4. Results arrive through an 8-word buffer.
 */
// Contract
// [R1] Data out changes only on falling clock
// [R2] Host uses clock idle low or high
// [R3] Host samples data on rising edges
// [R4] Output floats for first two pulses
// [R5] MSB appears on third falling edge
// [R6] First byte: two unknown, null, five MSBs
// [R7] Second byte: seven LSBs, then bit one again
// [R8] Byte hosts send two byte transfers
// [R9] Host realigns the two received bytes
// [R10] One result bit per received clock
// [R11] Host finishes twelve bits within limit
// [R12] No fixed clock rate or duty
// [R13] Acquire on first rise after select
// [R14] Second falling edge drives low null
// [R15] Zeros forever after LSB-first result
// [R16] Select high ends conversion, standby
`timescale 1ns/1ps
module asr_readout #(
   parameter int MAX_CONV_CYC = asr_pkg::MAX_CONV_CYC
) (
   input  wire logic                     CLK,           // System clock, 10 MHz
   input  wire logic                     RST_B,         // Asynchronous reset, active low
   input  wire logic                     SCLK,          // Serial clock pin
   input  wire logic                     SEL_STBY_B,    // Select and standby input, active low
   output logic                          DOUT,          // Serial data out
   output logic                          DOUT_OE,       // Data out driven when high
   input  wire logic                     SAMPLE_VALID,  // New result offered
   input  wire logic [asr_pkg::RES_W-1:0] SAMPLE_DATA,  // Result word
   output logic                          SAMPLE_READY,  // Buffer accepts a result
   output logic                          CONV_LATE,     // Bits not done within time limit
   output logic                          NO_SAMPLE      // Transfer started with empty buffer
);
   localparam int TW = $clog2(MAX_CONV_CYC + 1);

   typedef struct packed {
      logic                     cs_s1;
      logic                     cs_s2;
      logic                     ck_s1;
      logic                     ck_s2;
      logic                     ck_s3;
      logic                     armed;
      asr_pkg::asr_state_t      st;
      logic [1:0]               pulses;
      logic [3:0]               idx;
      logic [asr_pkg::RES_W-1:0] word;
      logic                     dout;
      logic                     oe;
      logic                     tmr_on;
      logic [TW-1:0]            tmr;
      logic                     late;
      logic                     empty;
   } asr_st_t;

   asr_st_t q;
   asr_st_t d;
   logic    sel;
   logic    rise;
   logic    fall;
   logic    pop;

   asr_fifo_if #(.W(asr_pkg::RES_W)) fif ();

   asr_fifo #(
      .W     (asr_pkg::RES_W),
      .DEPTH (asr_pkg::FIFO_DEPTH)
   ) u_fifo (
      .CLK   (CLK),
      .RST_B (RST_B),
      .f     (fif)
   );

   // User fill side and engine drain side of the buffer
   assign fif.wr_valid = SAMPLE_VALID;
   assign fif.wr_data  = SAMPLE_DATA;
   assign fif.rd_ready = pop;

   // Edge views of the synchronised pins
   assign sel  = !q.cs_s2;
   assign rise = q.ck_s2 && !q.ck_s3;   // [R12]
   assign fall = !q.ck_s2 && q.ck_s3;   // [R12]

   // Next-state logic of the read-out engine
   always_comb begin
      d     = q;
      pop   = 1'b0;
      d.cs_s1 = SEL_STBY_B;
      d.cs_s2 = q.cs_s1;
      d.ck_s1 = SCLK;
      d.ck_s2 = q.ck_s1;
      d.ck_s3 = q.ck_s2;
      // Powered up selected: a high is needed before the first transfer
      if (q.cs_s2) begin
         d.armed = 1'b1;
      end
      // Time limit from end of sampling to last MSB-first bit
      if (q.tmr_on) begin
         if (q.tmr == MAX_CONV_CYC[TW-1:0]) begin
            d.late   = 1'b1;
            d.tmr_on = 1'b0;
         end else begin
            d.tmr = q.tmr + 1'b1;
         end
      end
      if (!sel) begin
         d.st     = asr_pkg::ASR_IDLE;    // [R16]
         d.oe     = 1'b0;
         d.dout   = 1'b0;
         d.tmr_on = 1'b0;
      end else begin
         case (q.st)
            asr_pkg::ASR_IDLE: begin
               if (q.armed && rise) begin
                  d.st     = asr_pkg::ASR_SAMPLE;   // [R13]
                  d.pulses = 2'h1;
                  pop      = fif.rd_valid;
                  d.word   = fif.rd_valid ? fif.rd_data : '0;
                  d.empty  = !fif.rd_valid;
                  d.late   = 1'b0;
               end
            end
            asr_pkg::ASR_SAMPLE: begin
               // Output floats until the null bit goes out
               if (rise) begin
                  d.pulses = q.pulses + 1'b1;       // [R4]
               end else if (fall && q.pulses == asr_pkg::NULL_PULSE) begin
                  d.oe     = 1'b1;                  // [R14]
                  d.dout   = 1'b0;
                  d.st     = asr_pkg::ASR_MSB;
                  d.idx    = asr_pkg::MSB_IDX;
                  d.tmr    = '0;
                  d.tmr_on = 1'b1;
               end
            end
            asr_pkg::ASR_MSB: begin
               if (fall) begin
                  d.dout = q.word[q.idx];           // [R1] [R5] [R6] [R10]
                  if (q.idx == asr_pkg::LSB_IDX) begin
                     d.st     = asr_pkg::ASR_LSB;
                     d.idx    = asr_pkg::LSB_RESTART;
                     d.tmr_on = 1'b0;
                  end else begin
                     d.idx = q.idx - 1'b1;
                  end
               end
            end
            asr_pkg::ASR_LSB: begin
               if (fall) begin
                  d.dout = q.word[q.idx];           // [R1] [R7]
                  if (q.idx == asr_pkg::MSB_IDX) begin
                     d.st = asr_pkg::ASR_ZERO;
                  end else begin
                     d.idx = q.idx + 1'b1;
                  end
               end
            end
            asr_pkg::ASR_ZERO: begin
               if (fall) begin
                  d.dout = 1'b0;                    // [R15]
               end
            end
            default: begin
               d.st = asr_pkg::ASR_IDLE;
               d.oe = 1'b0;
            end
         endcase
      end
   end

   // State register; the select synchroniser starts low, so only a high really seen on the pin arms the engine
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         q       <= '0;
         q.st    <= asr_pkg::ASR_IDLE;
      end else begin
         q <= d;
      end
   end

   // Outputs straight from flops
   assign DOUT         = q.dout;
   assign DOUT_OE      = q.oe;
   assign SAMPLE_READY = fif.wr_ready;
   assign CONV_LATE    = q.late;
   assign NO_SAMPLE    = q.empty;

   dout_on_fall_a: assert property (@(posedge CLK) disable iff (!RST_B) // [R1]
      ($changed(DOUT) && $past(sel)) |-> $past(fall))
      else $error("Data out changed without a falling edge");

   hiz_first_pulses_a: assert property (@(posedge CLK) disable iff (!RST_B) // [R4]
      (q.st == asr_pkg::ASR_SAMPLE) |-> !DOUT_OE)
      else $error("Data out driven during sampling pulses");

   null_bit_low_a: assert property (@(posedge CLK) disable iff (!RST_B) // [R14]
      $rose(DOUT_OE) |-> (!DOUT && q.st == asr_pkg::ASR_MSB && q.idx == asr_pkg::MSB_IDX))
      else $error("Null bit not low at start of output");

   msb_third_fall_a: assert property (@(posedge CLK) disable iff (!RST_B) // [R5]
      (sel && q.st == asr_pkg::ASR_MSB && fall && q.idx == asr_pkg::MSB_IDX) |=> (DOUT == q.word[asr_pkg::MSB_IDX]))
      else $error("MSB not presented on third falling edge");

   lsb_repeat_a: assert property (@(posedge CLK) disable iff (!RST_B) // [R7]
      (sel && q.st == asr_pkg::ASR_MSB && fall && q.idx == asr_pkg::LSB_IDX) |=>
      (q.st == asr_pkg::ASR_LSB && q.idx == asr_pkg::LSB_RESTART))
      else $error("LSB-first phase does not restart at bit one");

   one_bit_clock_a: assert property (@(posedge CLK) disable iff (!RST_B) // [R10]
      (sel && q.st == asr_pkg::ASR_MSB && fall && q.idx != asr_pkg::LSB_IDX) |=> (q.idx == $past(q.idx) - 4'h1))
      else $error("Not one bit per serial clock");

   zeros_after_a: assert property (@(posedge CLK) disable iff (!RST_B) // [R15]
      (sel && q.st == asr_pkg::ASR_ZERO && fall) |=> (!DOUT && DOUT_OE))
      else $error("Nonzero data after LSB-first result");

   acquire_rise_a: assert property (@(posedge CLK) disable iff (!RST_B) // [R13]
      (sel && q.armed && q.st == asr_pkg::ASR_IDLE && rise) |=> (q.st == asr_pkg::ASR_SAMPLE && q.pulses == 2'h1))
      else $error("Acquisition not started on first rise");

   standby_deselect_a: assert property (@(posedge CLK) disable iff (!RST_B) // [R16]
      !sel |=> (q.st == asr_pkg::ASR_IDLE && !DOUT_OE))
      else $error("Deselect did not end the conversion");
endmodule

// *** logic/asr_pkg.sv ***
/*
 * Shared constants and types of the serial result read-out block.
 * Assumes a 10 MHz system clock; all serial pins are asynchronous to it.
 */
package asr_pkg;
   // Result and buffer shape
   localparam int          RES_W        = 12;
   localparam int          FIFO_DEPTH   = 8;
   // Bit positions in the shifted sequence
   localparam logic [3:0]  MSB_IDX      = 4'hb;
   localparam logic [3:0]  LSB_IDX      = 4'h0;
   localparam logic [3:0]  LSB_RESTART  = 4'h1;
   localparam logic [1:0]  NULL_PULSE   = 2'h2;
   // Longest allowed time from end of sampling to last MSB-first result bit
   localparam int          CLK_KHZ      = 10000;
   localparam int          MAX_CONV_US  = 1200;
   localparam int          MAX_CONV_CYC = (MAX_CONV_US * CLK_KHZ) / 1000;

   // Read-out sequence states, one-hot
   typedef enum logic [4:0] {
      ASR_IDLE   = 5'h01,
      ASR_SAMPLE = 5'h02,
      ASR_MSB    = 5'h04,
      ASR_LSB    = 5'h08,
      ASR_ZERO   = 5'h10
   } asr_state_t;
endpackage

// *** logic/asr_fifo_if.sv ***
/*
 * Carrier between the read-out engine and its result buffer.
 * Assumes both ends sit on the same clock.
 */
`timescale 1ns/1ps
interface asr_fifo_if #(
   parameter int W = 12
);
   logic         wr_valid;   // Producer offers a word
   logic         wr_ready;   // Buffer can take a word
   logic [W-1:0] wr_data;    // Word offered
   logic         rd_valid;   // Buffer holds a word
   logic         rd_ready;   // Consumer takes the head word
   logic [W-1:0] rd_data;    // Head word

   modport buf_end (input wr_valid, wr_data, rd_ready, output wr_ready, rd_valid, rd_data);
   modport use_end (output wr_valid, wr_data, rd_ready, input wr_ready, rd_valid, rd_data);
endinterface

// *** logic/asr_fifo.sv ***
/*
 * Result buffer: power-of-two depth FIFO with registered ready and valid.
 * Assumes one clock, asynchronous active-low reset.
 */
`timescale 1ns/1ps
module asr_fifo #(
   parameter int W     = 12,
   parameter int DEPTH = 8
) (
   input  wire logic CLK,       // System clock
   input  wire logic RST_B,     // Asynchronous reset, active low
   asr_fifo_if.buf_end f        // Fill and drain sides
);
   localparam int PW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [PW-1:0]           wptr;
      logic [PW-1:0]           rptr;
      logic [PW:0]             cnt;
      logic                    rdy;
      logic                    vld;
   } asr_fifo_st_t;

   asr_fifo_st_t q;
   asr_fifo_st_t d;
   logic         wr;
   logic         rd;

   // Handshakes, pointer moves and honest full and empty
   always_comb begin
      d  = q;
      wr = f.wr_valid && q.rdy;
      rd = f.rd_ready && q.vld;
      if (wr) begin
         d.mem[q.wptr] = f.wr_data;
         d.wptr        = q.wptr + 1'b1;
      end
      if (rd) begin
         d.rptr = q.rptr + 1'b1;
      end
      if (wr && !rd) begin
         d.cnt = q.cnt + 1'b1;
      end else if (rd && !wr) begin
         d.cnt = q.cnt - 1'b1;
      end
      d.rdy = (d.cnt != DEPTH[PW:0]);
      d.vld = (d.cnt != '0);
   end

   // State register
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         q     <= '0;
         q.rdy <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign f.wr_ready = q.rdy;
   assign f.rd_valid = q.vld;
   assign f.rd_data  = q.mem[q.rptr];

   // Full buffer never takes a word
   no_overfill_a: assert property (@(posedge CLK) disable iff (!RST_B)
      (q.cnt == DEPTH[PW:0]) |-> !f.wr_ready)
      else $error("Buffer full but ready");
endmodule

// *** dv/asr_host.sv ***
/*
 * Host serial port model: drives select and serial clock, samples data.
 * Assumes it is called just after a falling CLK edge; halves of >= 4 CLK.
 */
`timescale 1ns/1ps
module asr_host (
   input  wire logic CLK,         // System clock
   output logic      SCLK,        // Serial clock to device
   output logic      SEL_STBY_B,  // Select, active low
   input  wire logic DIN,         // Resolved data pin
   input  wire logic DIN_OE       // Device drives data pin
);
   logic rx_d  [1:40];  // Data seen per pulse
   logic rx_oe [1:40];  // Drive state seen per pulse
   int   hi_edges;      // Data moves seen while clock high
   logic sclk_p;        // Clock level at the previous edge
   logic din_p;         // Data level at the previous edge
   logic oe_p;          // Drive state at the previous edge

   // Idle: deselected, clock low
   initial begin
      SCLK = 1'b0;
      SEL_STBY_B = 1'b1;
      hi_edges = 0;
   end

   // Counts pin changes inside a clock-high phase
   always @(posedge CLK) begin
      if (SCLK && sclk_p && !SEL_STBY_B && ({DIN, DIN_OE} !== {din_p, oe_p}))
         hi_edges++;
      sclk_p <= SCLK;
      din_p  <= DIN;
      oe_p   <= DIN_OE;
   end

   // Holds select low, as a host that was already selected at reset
   task automatic hold_sel();
      SEL_STBY_B = 1'b0;
   endtask

   // Pulses under a select that was never high since reset, then a deselect
   task automatic stray(input int pulses, input int half);
      for (int n = 1; n <= pulses; n++) begin
         SCLK = 1'b0;
         repeat (half) @(negedge CLK);
         SCLK = 1'b1;
         rx_oe[n] = DIN_OE;
         repeat (half) @(negedge CLK);
      end
      SCLK = 1'b0;
      repeat (6) @(negedge CLK);
      rx_oe[pulses + 1] = DIN_OE;
      SEL_STBY_B = 1'b1;
      repeat (6) @(negedge CLK);
   endtask

   // One select frame of the given pulse count and phase lengths
   task automatic run(input int pulses, input logic mode, input int hi, input int lo);
      SCLK = mode;                  // Idle level picks the mode
      @(negedge CLK);
      SEL_STBY_B = 1'b0;
      repeat (6) @(negedge CLK);
      for (int n = 1; n <= pulses; n++) begin
         SCLK = 1'b0;
         repeat (lo) @(negedge CLK);
         SCLK = 1'b1;
         rx_d[n] = DIN;             // Latch on rising edge
         rx_oe[n] = DIN_OE;
         repeat (hi) @(negedge CLK); // Phase lengths set the pace
      end
      SCLK = mode;
      repeat (6) @(negedge CLK);
      SEL_STBY_B = 1'b1;            // Deselect between conversions
      repeat (6) @(negedge CLK);
   endtask
endmodule

// *** dv/asr_readout_test.sv ***
/*
 * Self-checking bench of the serial result read-out.
 * Assumes the host model drives the serial pins and the bench the buffer.
 */
`timescale 1ns/1ps
module asr_readout_test;
   logic        clk, rst_b, sv, sr, late, nos, dout, oe, sclk, sel;
   logic [11:0] sd;
   logic [11:0] q [$];  // Words expected in order
   int          n_fail, checked;
   wire         dpin = oe ? dout : 1'bz;  // Pin floats when released
   localparam logic [11:0] WORDS [8] = '{12'h801, 12'hfff, 12'h000, 12'ha5c,
                                         12'h3c6, 12'h001, 12'h7fe, 12'h5a5};
   localparam int CONV_CYC = 200;  // Shortened time limit for the run

   asr_readout #(.MAX_CONV_CYC(CONV_CYC)) u_dut (.CLK(clk), .RST_B(rst_b), .SCLK(sclk),
      .SEL_STBY_B(sel), .DOUT(dout), .DOUT_OE(oe), .SAMPLE_VALID(sv), .SAMPLE_DATA(sd),
      .SAMPLE_READY(sr), .CONV_LATE(late), .NO_SAMPLE(nos));
   asr_host u_host (.CLK(clk), .SCLK(sclk), .SEL_STBY_B(sel), .DIN(dpin), .DIN_OE(oe));

   // 100 ns clock
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic chk1(input logic got, input logic exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk12(input logic [11:0] got, input logic [11:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Value seen at rise n, driven at the fall of pulse n-1
   function automatic logic exp_bit(input logic [11:0] w, input int n);
      int k;
      k = n - 1;
      if (k >= 3 && k <= 14) return w[14-k];
      if (k >= 15 && k <= 25) return w[k-14];
      return 1'b0;
   endfunction

   // One frame, judged bit by bit, then for 16 pulses realigned as a byte host would
   task automatic do_xfer(input int pulses, input logic mode, input int hi, input int lo, input logic empty);
      logic [11:0] w;
      logic [7:0]  hb, lb;
      w = empty ? 12'h000 : q.pop_front();
      u_host.run(pulses, mode, hi, lo);
      for (int n = 1; n <= pulses; n++) begin
         chk1(u_host.rx_oe[n], n > 2);
         if (n > 2) chk1(u_host.rx_d[n], exp_bit(w, n));
      end
      chk1(u_host.hi_edges == 0, 1'b1);
      chk1(oe, 1'b0);
      chk1(nos, empty);
      chk1(late, pulses >= 14 && 12 * (hi + lo) > CONV_CYC);
      if (pulses == 16) begin
         for (int i = 0; i < 8; i++) begin
            hb[7-i] = u_host.rx_d[i+1];
            lb[7-i] = u_host.rx_d[i+9];
         end
         lb = lb >> 1;
         lb[7] = hb[0];
         hb = hb >> 1;
         chk12({hb[3:0], lb}, w);
      end
   endtask

   // Fill the buffer until it refuses
   task automatic t_fill();
      for (int i = 0; i < 8; i++) begin
         sv = 1'b1;
         sd = WORDS[i];
         q.push_back(WORDS[i]);
         @(negedge clk);
      end
      sv = 1'b0;
      @(negedge clk);
      chk1(sr, 1'b0);
   endtask

   task automatic t_empty();  do_xfer(16, 1'b0, 6, 6, 1'b1);  endtask
   task automatic t_mode0();  do_xfer(16, 1'b0, 6, 6, 1'b0); chk1(sr, 1'b1);  endtask
   task automatic t_mode1();  do_xfer(16, 1'b1, 6, 6, 1'b0);  endtask
   task automatic t_long();   do_xfer(30, 1'b0, 6, 6, 1'b0);  endtask
   task automatic t_duty();   do_xfer(16, 1'b1, 4, 9, 1'b0);  endtask
   task automatic t_slow();   do_xfer(16, 1'b0, 10, 10, 1'b0);  endtask
   task automatic t_abort();  do_xfer(6, 1'b0, 6, 6, 1'b0); chk1(dout, 1'b0);  endtask

   // Reset in mid-run while selected: pulses ignored until a deselect, then a frame from the empty buffer
   task automatic t_rearm();
      u_host.hold_sel();
      repeat (3) @(negedge clk);
      rst_b = 1'b0;
      repeat (5) @(negedge clk);
      rst_b = 1'b1;
      for (int i = 0; i < 2; i++) begin
         @(negedge clk);
         chk1(oe, 1'b0);
         chk1(sr, 1'b1);
         chk1(late, 1'b0);
         chk1(nos, 1'b0);
      end
      u_host.stray(4, 6);
      for (int n = 1; n <= 5; n++) begin
         chk1(u_host.rx_oe[n], 1'b0);
      end
      chk1(nos, 1'b0);
      do_xfer(16, 1'b0, 6, 6, 1'b1);
   endtask

   task automatic wrap_up();
      $display("Checks %0d, mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // Main sequence
   initial begin
      n_fail = 0;
      checked = 0;
      rst_b = 1'b0;
      sv = 1'b0;
      sd = 12'h000;
      repeat (5) @(negedge clk);
      rst_b = 1'b1;
      repeat (6) @(negedge clk);
      chk1(oe, 1'b0);
      chk1(sr, 1'b1);
      chk1(late, 1'b0);
      chk1(nos, 1'b0);
      t_empty();
      t_fill();
      t_mode0();
      t_mode1();
      t_long();
      t_duty();
      t_slow();
      t_abort();
      t_mode0();
      t_mode1();
      t_rearm();
      wrap_up();
   end

   // Hang guard
   initial begin
      repeat (20000) @(negedge clk);
      n_fail++;
      wrap_up();
   end
endmodule
